// ### core/old_diag_map.svh
// Named constants for the open-load diagnostics block.
// Assumes a 20 MHz system clock; included by the package user files.
`ifndef OLD_DIAG_MAP_SVH
`define OLD_DIAG_MAP_SVH
`define OLD_NCH         5
`define OLD_CLK_KHZ     20000
`define OLD_T_BULB_US   64
`define OLD_T_CONV_US   2000
`define OLD_T_LED_US    2000
`define OLD_T_SRC_US    100
`define OLD_T_OFF_US    1200
`define OLD_T_FLT_NS    3300
`define OLD_CYC_BULB    ((`OLD_T_BULB_US * `OLD_CLK_KHZ) / 1000)
`define OLD_CYC_CONV    ((`OLD_T_CONV_US * `OLD_CLK_KHZ) / 1000)
`define OLD_CYC_LED     ((`OLD_T_LED_US * `OLD_CLK_KHZ) / 1000)
`define OLD_CYC_SRC     ((`OLD_T_SRC_US * `OLD_CLK_KHZ) / 1000)
`define OLD_CYC_OFF     ((`OLD_T_OFF_US * `OLD_CLK_KHZ) / 1000)
`define OLD_CYC_FLT     ((`OLD_T_FLT_NS * `OLD_CLK_KHZ + 999999) / 1000000)
`define OLD_CNT_W       16
`endif

// ### core/old_pkg.sv
// Types shared by the open-load diagnostics block.
// Assumes old_diag_map.svh sits on the include path.
`include "old_diag_map.svh"
package old_pkg;
  typedef logic [`OLD_NCH-1:0] old_chan_t;
  typedef logic [`OLD_CNT_W-1:0] old_cnt_t;
  // Per-channel configuration bits written by the controller.
  typedef struct packed {
    old_chan_t ledDetectEnable;
    old_chan_t onOpenDeglitchSelect;
  } old_cfg_t;
  // Per-channel latched status bits.
  typedef struct packed {
    old_chan_t channelQuickFlag;
    old_chan_t onOpenFlag;
    old_chan_t offOpenFlag;
  } old_stat_t;
  // Off-state test sequencer states per channel.
  typedef enum logic [2:0] {
    OFF_IDLE = 3'b001,
    OFF_RUN  = 3'b010,
    OFF_ABRT = 3'b100
  } old_off_t;
endpackage

// ### core/old_diag.sv
// Open-load diagnostics for five high side outputs.
// Holds the on-state, LED and off-state checks and their latched flags.
// Flags latch here and clear on the per-channel status read strobes.
// Timing counts come from the map header and a 20 MHz clock.
// Framing of the serial bus and register decode live outside this file.
// Assumes synchronous inputs and a controller that reads status words.
// Operation
// [RL1] On-state check runs whenever output is on
// [RL2] Deglitch select picks 64 us or 2 ms
// [RL3] Deglitch filter clears when output falls low
// [RL4] On-state open load never switches output off
// [RL5] On result sets quick, global, on flags
// [RL6] On flag clears after fault gone and read
// [RL7] LED enable selects LED or standard check
// [RL8] LED fault after 2 ms or at turn-on
// [RL9] PWM LED check runs off-time, max 2 ms
// [RL10] Source off on pass or after 2 ms
// [RL11] Trigger at full duty; source off 100 us
// [RL12] Trigger bit self-clears after detection
// [RL13] Off test 1.2 ms, not restartable or cancelable
// [RL14] Enabled off tests start at chip-select rise
// [RL15] Threshold reached: off, clear enable, no fault
// [RL16] Timeout: off, clear enable, set off flag
// [RL17] Off test leaves overcurrent and sensing alone
// [RL18] Off result sets flags cleared by read
// [RL19] Device fault aborts test after deglitch time
// [RL20] Short-to-supply bit follows comparator live
// [RL21] Global flag clears when all channels clear
// [RL22] Counters run on clock, restart per test
`timescale 1ns/1ps
`include "old_diag_map.svh"
module old_diag (
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire old_pkg::old_cfg_t cfg,
  input  wire old_pkg::old_chan_t outputOn,
  input  wire old_pkg::old_chan_t loadCurrentLow,
  input  wire old_pkg::old_chan_t ledCompHigh,
  input  wire old_pkg::old_chan_t outputLevelBit,
  input  wire old_pkg::old_chan_t offCurrentReached,
  input  wire old_pkg::old_chan_t offTestEnableWrite,
  input  wire logic              offTestWriteStrobe,
  input  wire logic              chipSelectRise,
  input  wire logic              ledTriggerSet,
  input  wire logic              undervoltageFlag,
  input  wire logic              overtempShutdown,
  input  wire logic              chargePumpFault,
  input  wire old_pkg::old_chan_t statusRead,
  output old_pkg::old_stat_t     status,
  output logic                   globalOpenFlag,
  output old_pkg::old_chan_t     offTestEnable,
  output old_pkg::old_chan_t     offTestDrive,
  output old_pkg::old_chan_t     ledTestCurrent,
  output logic                   ledDetectTrigger,
  output old_pkg::old_chan_t     outputLevelStat
);
  import old_pkg::*;

  // Interval lengths in clock cycles, fixed by the map header.
  // All of them fit the 16-bit counter; the longest is the 2 ms
  // converter and LED window at 40000 cycles.
  localparam old_cnt_t CycBulb = old_cnt_t'(`OLD_CYC_BULB);
  localparam old_cnt_t CycConv = old_cnt_t'(`OLD_CYC_CONV);
  localparam old_cnt_t CycLed  = old_cnt_t'(`OLD_CYC_LED);
  localparam old_cnt_t CycSrc  = old_cnt_t'(`OLD_CYC_SRC);
  localparam old_cnt_t CycOff  = old_cnt_t'(`OLD_CYC_OFF);
  localparam old_cnt_t CycFlt  = old_cnt_t'(`OLD_CYC_FLT);

  // Latched flags, the events that set them, and the live-fault and trigger-done terms.
  old_chan_t onOpenFlag_r;
  old_chan_t offOpenFlag_r;
  old_chan_t quick_r;
  old_chan_t onEvt;
  old_chan_t offEvt;
  old_chan_t onFaultLive;
  old_chan_t trigDone;
  // Registered copies of the off-test, LED source and level status outputs.
  old_chan_t offEn_r;
  old_chan_t offDrv_r;
  old_chan_t ledSrc_r;
  old_chan_t outLvl_r;
  // Device-wide state: global flag, trigger and fault summary.
  logic      glob_r;
  logic      trig_r;
  logic      devFault;
  logic      trigPend_r;

  // Any device fault aborts a running off-state test.
  // Undervoltage is included, as the test result cannot be trusted then.
  assign devFault = undervoltageFlag | overtempShutdown | chargePumpFault;

  // One copy of the channel logic per output; channels share nothing
  // but the device fault summary, the LED trigger, the write strobe and the chip-select edge.
  genvar g;
  generate
    for (g = 0; g < `OLD_NCH; g++) begin : gChan
      // Per-channel counters and state; each channel runs on its own
      // and restarts its counters whenever its check starts again.
      old_cnt_t dglCnt_r;
      old_cnt_t ledCnt_r;
      old_cnt_t offCnt_r;
      old_off_t offSt_r;
      logic     outPrev_r;
      logic     ledActive_r;
      logic     ledFull_r;
      logic     srcHold_r;
      old_cnt_t srcCnt_r;
      old_cnt_t dglLimit;
      logic     turnOn;
      logic     turnOff;
      logic     trigStart;

      // Deglitch length picked per channel by the select bit.
      assign dglLimit = cfg.onOpenDeglitchSelect[g] ? CycConv : CycBulb; // [RL2]
      assign turnOn   = outputOn[g] & ~outPrev_r;
      assign turnOff  = ~outputOn[g] & outPrev_r;
      // A trigger opens a check only in the cycle after it is set, so a
      // check that ends while the trigger is still up does not rerun.
      assign trigStart = trig_r & ~trigPend_r & outputOn[g] & ~ledActive_r;

      // Last output level, for turn-on and turn-off edges.
      // It resets low, the idle level of an off output, so no false edge.
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          outPrev_r <= 1'b0;
        end else begin
          outPrev_r <= outputOn[g];
        end
      end

      // Standard on-state filter counts only while the output is high.
      // A normal current or a low output restarts it, so only an unbroken
      // open-load spell of the full deglitch length is reported.
      always_ff @(posedge sys_clk) begin
        if (reset || !outputOn[g] || !loadCurrentLow[g]) begin
          dglCnt_r <= '0; // [RL3] [RL22]
        end else if (!cfg.ledDetectEnable[g] && dglCnt_r < dglLimit) begin
          dglCnt_r <= dglCnt_r + 1'b1; // [RL1] [RL7]
        end
      end
      // The live fault keeps its flag from delatching while it persists.
      // It is masked in LED mode, where the flag clears on a read alone.
      assign onFaultLive[g] = ~cfg.ledDetectEnable[g] & outputOn[g] &
                              loadCurrentLow[g] & (dglCnt_r == dglLimit);

      // LED check: opens at each turn-off, or on trigger at full duty.
      // It closes when the comparator drops, at turn-on, or at 2 ms;
      // whichever comes first ends the window.
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          ledActive_r <= 1'b0;
          ledFull_r   <= 1'b0;
          ledCnt_r    <= '0;
        end else if (!cfg.ledDetectEnable[g]) begin
          ledActive_r <= 1'b0; // [RL7]
          ledFull_r   <= 1'b0;
          ledCnt_r    <= '0;
        end else if (turnOff || trigStart) begin
          ledActive_r <= 1'b1; // [RL9] [RL11]
          ledFull_r   <= ~turnOff;
          ledCnt_r    <= '0; // [RL22]
        end else if (ledActive_r) begin
          // The counter may run one step past the limit; the window is
          // already closed by then, so the extra count is never read.
          if (!ledCompHigh[g] || turnOn || ledCnt_r == CycLed) begin
            ledActive_r <= 1'b0; // [RL8] [RL10]
          end
          ledCnt_r <= ledCnt_r + 1'b1;
        end
      end
      // Verdict: comparator still high at timeout or at turn-on.
      // Short off-times therefore decide at every turn-on command.
      assign onEvt[g] = onFaultLive[g] | (ledActive_r & ledCompHigh[g] &
                        (turnOn | ledCnt_r == CycLed)); // [RL5] [RL8]
      // A channel counts as done unless a triggered check is still open;
      // channels outside LED mode never hold the trigger up.
      assign trigDone[g] = ~(ledActive_r & ledFull_r);

      // Source stays on 100 us past reactivation in triggered mode.
      // The tail lets the output settle before the source is dropped;
      // leaving LED mode cuts the tail at once.
      always_ff @(posedge sys_clk) begin
        if (reset || !cfg.ledDetectEnable[g]) begin
          srcHold_r <= 1'b0;
          srcCnt_r  <= '0;
        end else if (ledActive_r && ledFull_r && ledCnt_r == CycLed) begin
          srcHold_r <= 1'b1; // [RL11]
          srcCnt_r  <= '0;
        end else if (srcHold_r) begin
          srcCnt_r  <= srcCnt_r + 1'b1;
          srcHold_r <= (srcCnt_r != CycSrc);
        end
      end

      // Source is lit only during the check or its tail.
      // Dropping it on a passing comparator saves supply current, at the
      // cost of one cycle of lag behind the window.
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          ledSrc_r[g] <= 1'b0;
        end else begin
          ledSrc_r[g] <= (ledActive_r & ledCompHigh[g] &
                          ledCnt_r != CycLed) | srcHold_r; // [RL10]
        end
      end

      // Off-state test sequencer; a device fault aborts after deglitch.
      // A running test cannot be restarted or cancelled: writes are only
      // taken while idle.
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          offSt_r       <= OFF_IDLE;
          offCnt_r      <= '0;
          offEn_r[g]    <= 1'b0; // [RL13]
          offDrv_r[g]   <= 1'b0;
          offEvt[g]     <= 1'b0;
        end else begin
          // The fault event strobe lasts a single cycle.
          offEvt[g] <= 1'b0;
          case (offSt_r)
            // Idle: take enable writes, and start every enabled channel
            // together on the chip-select edge that closes the write.
            OFF_IDLE: begin
              if (offTestWriteStrobe) begin
                offEn_r[g] <= offTestEnableWrite[g];
              end
              if (chipSelectRise && offEn_r[g]) begin
                offSt_r     <= OFF_RUN; // [RL14]
                offCnt_r    <= '0; // [RL22]
                offDrv_r[g] <= 1'b1; // [RL15] [RL17]
              end
            end
            // Running: the channel is driven with the fixed threshold
            // until the current arrives, the time runs out or a fault.
            OFF_RUN: begin
              offCnt_r <= offCnt_r + 1'b1; // [RL13]
              // A device fault outranks a pass or a timeout in one cycle,
              // so an aborted test never reports an open load.
              if (devFault) begin
                offSt_r  <= OFF_ABRT; // [RL19]
                offCnt_r <= '0;
              end else if (offCurrentReached[g]) begin
                offSt_r     <= OFF_IDLE; // [RL15]
                offDrv_r[g] <= 1'b0;
                offEn_r[g]  <= 1'b0;
              end else if (offCnt_r == CycOff) begin
                offSt_r     <= OFF_IDLE; // [RL16]
                offDrv_r[g] <= 1'b0;
                offEn_r[g]  <= 1'b0;
                offEvt[g]   <= 1'b1;
              end
            end
            // Aborting: the drive is held for the fault deglitch time,
            // then dropped with its enable and no open-load result.
            OFF_ABRT: begin
              offCnt_r <= offCnt_r + 1'b1;
              if (offCnt_r == CycFlt) begin
                offSt_r     <= OFF_IDLE; // [RL19]
                offDrv_r[g] <= 1'b0;
                offEn_r[g]  <= 1'b0;
              end
            end
            default: begin
              offSt_r <= OFF_IDLE;
            end
          endcase
        end
      end

      // Sticky flags; a new event wins over a read in the same cycle.
      // Letting the set win means a fault that lands on a read is never
      // lost; the controller sees it on its next read.
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          onOpenFlag_r[g]  <= 1'b0;
          offOpenFlag_r[g] <= 1'b0;
        end else begin
          // The on flag also waits for the live fault to go away.
          if (onEvt[g]) begin
            onOpenFlag_r[g] <= 1'b1; // [RL4] [RL5]
          end else if (statusRead[g] && !onFaultLive[g]) begin
            onOpenFlag_r[g] <= 1'b0; // [RL6]
          end
          if (offEvt[g]) begin
            offOpenFlag_r[g] <= 1'b1; // [RL18]
          end else if (statusRead[g]) begin
            offOpenFlag_r[g] <= 1'b0; // [RL18]
          end
        end
      end
    end
  endgenerate

  // Quick flags mirror the channel flags; they set with the latch and clear one cycle after it.
  // The events are folded in so the quick and global flags never miss a
  // fault that is set and read away in back-to-back cycles.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      quick_r <= '0;
      glob_r  <= 1'b0;
    end else begin
      quick_r <= onOpenFlag_r | offOpenFlag_r | onEvt | offEvt; // [RL5]
      glob_r  <= |(onOpenFlag_r | offOpenFlag_r | onEvt | offEvt); // [RL21]
    end
  end

  // Trigger holds until every triggered check has finished.
  // The pending bit spends one cycle letting the channels open their
  // checks before completion is judged; otherwise the trigger would
  // clear in the very cycle the checks start.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      trig_r     <= 1'b0;
      trigPend_r <= 1'b0;
    end else if (ledTriggerSet) begin
      trig_r     <= 1'b1; // [RL11]
      trigPend_r <= 1'b0;
    end else if (trig_r && !trigPend_r) begin
      trigPend_r <= 1'b1;
    end else if (trig_r && (&trigDone)) begin
      trig_r     <= 1'b0; // [RL12]
      trigPend_r <= 1'b0;
    end
  end

  // Live comparator copy, forced low in undervoltage as it is undefined.
  // It is not latched: one register stage is its only delay.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      outLvl_r <= '0;
    end else begin
      outLvl_r <= undervoltageFlag ? '0 : outputLevelBit; // [RL20]
    end
  end

  // Every output is a register or a group of registers.
  // The status word packs quick, on-state and off-state flags.
  assign status           = '{quick_r, onOpenFlag_r, offOpenFlag_r};
  assign globalOpenFlag   = glob_r;
  assign offTestEnable    = offEn_r;
  assign offTestDrive     = offDrv_r;
  assign ledTestCurrent   = ledSrc_r;
  assign ledDetectTrigger = trig_r;
  assign outputLevelStat  = outLvl_r;
endmodule

// ### verif/old_diag_asserts.sv
// Concurrent checks on the ports of the open-load diagnostics block.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module old_diag_asserts (
  input wire logic               sys_clk,
  input wire logic               reset,
  input wire old_pkg::old_cfg_t  cfg,
  input wire old_pkg::old_chan_t loadCurrentLow,
  input wire old_pkg::old_chan_t outputLevelBit,
  input wire old_pkg::old_chan_t offCurrentReached,
  input wire logic               chipSelectRise,
  input wire logic               undervoltageFlag,
  input wire old_pkg::old_stat_t status,
  input wire logic               globalOpenFlag,
  input wire old_pkg::old_chan_t offTestEnable,
  input wire old_pkg::old_chan_t offTestDrive,
  input wire old_pkg::old_chan_t outputLevelStat
);
  import old_pkg::*;
  // Every check shares the one clock, and reset masks them all.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Test drives start together, and only on the closing chip-select edge.
  a_start_on_cs: assert property (
    (offTestDrive & ~$past(offTestDrive)) != 0 |-> $past(chipSelectRise))
    else $error("test drive started without chip-select rise");
  a_cs_starts: assert property (
    chipSelectRise && offTestDrive == 0 |=>
    (offTestDrive & $past(offTestEnable)) == $past(offTestEnable))
    else $error("enabled channel not driven after chip-select rise");
  // A reached threshold ends the drive almost at once.
  a_pass_stops: assert property (
    (offTestDrive & offCurrentReached) != 0 |-> ##[1:2]
    (offTestDrive & $past(offTestDrive & offCurrentReached)) == 0)
    else $error("drive held after threshold reached");
  a_enable_drops: assert property (
    (($past(offTestDrive) & ~offTestDrive) & offTestEnable) == 0)
    else $error("enable left set after test drive ended");
  // The off flag may only appear within two cycles of a test drive.
  a_off_flag_src: assert property (
    (status.offOpenFlag & ~$past(status.offOpenFlag) &
     ~($past(offTestDrive) | $past(offTestDrive, 2))) == 0)
    else $error("off flag rose without an ending test");
  a_on_needs_low: assert property (
    (status.onOpenFlag & ~$past(status.onOpenFlag) & ~cfg.ledDetectEnable
     & ~($past(loadCurrentLow) | $past(loadCurrentLow, 2))) == 0)
    else $error("on flag rose without low load current");
  // The global flag mirrors the channel flags with a short lag.
  a_global_set: assert property (
    (status.onOpenFlag | status.offOpenFlag) != 0 |-> ##[0:2] globalOpenFlag)
    else $error("global flag missing while a channel flag is set");
  a_global_clear: assert property (
    (status == '0) ##1 (status == '0) |-> !globalOpenFlag)
    else $error("global flag set with all channel flags clear");
  // The level status is live, one register stage behind its comparator.
  a_level_live: assert property (
    !$past(reset) && !$past(undervoltageFlag) |->
    outputLevelStat == $past(outputLevelBit))
    else $error("level status does not follow the comparator");
endmodule
bind old_diag old_diag_asserts chk (
  .sys_clk, .reset, .cfg, .loadCurrentLow, .outputLevelBit,
  .offCurrentReached, .chipSelectRise, .undervoltageFlag, .status,
  .globalOpenFlag, .offTestEnable, .offTestDrive, .outputLevelStat
);

// ### verif/old_load_model.sv
// Model of the loads behind the five outputs of the diagnostics block.
// Assumes the bench states which channels have an open load.
`timescale 1ns/1ps
module old_load_model #(
  parameter int PASS_DLY = 40
) (
  input  wire logic           sys_clk,
  input  wire old_pkg::old_chan_t outputOn,
  input  wire old_pkg::old_chan_t offTestDrive,
  input  wire old_pkg::old_chan_t openLoad,
  output old_pkg::old_chan_t  loadCurrentLow,
  output old_pkg::old_chan_t  offCurrentReached
);
  import old_pkg::*;
  localparam int N = $bits(old_chan_t);
  int unsigned age [N];
  // Only a switched-on output with a missing load reads low current.
  assign loadCurrentLow = outputOn & openLoad;
  // Current takes a while to build, so a pass is never instant.
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < N; i++) begin
      age[i] <= offTestDrive[i] ? age[i] + 1 : 0;
      offCurrentReached[i] <= offTestDrive[i] && !openLoad[i]
                              && age[i] >= PASS_DLY;
    end
  end
endmodule

// ### verif/test_old_diag.sv
// Directed bench for the diagnostics block with a load model beside it.
// Assumes a 20 MHz clock and the fixed counts of the map header.
`timescale 1ns/1ps
module test_old_diag;
  import old_pkg::*;
  logic      sys_clk = 0, reset = 1, wrStb = 0, csRise = 0, uv = 0, overtemp_shutdown = 0;
  old_chan_t ledHi = '0;
  old_cfg_t  cfg = '0;
  old_chan_t outOn = '0, openLd = '0, lvl = '0, wrEn = '0, rdCh = '0;
  old_chan_t curLow, curOk, offEn, offDrv, lvlStat, ledSrc;
  old_stat_t status;
  logic      gFlag, trig;
  int        errors = 0, checks_done = 0;
  // The clock toggles every 25 ns, half of its 50 ns period.
  always #25 sys_clk = ~sys_clk;
  // The trigger and pump fault inputs stay quiet.
  old_diag DUT (
    .sys_clk, .reset, .cfg, .status, .outputOn(outOn),
    .loadCurrentLow(curLow), .ledCompHigh(ledHi), .outputLevelBit(lvl),
    .offCurrentReached(curOk), .offTestEnableWrite(wrEn),
    .offTestWriteStrobe(wrStb), .chipSelectRise(csRise),
    .ledTriggerSet(1'b0), .undervoltageFlag(uv), .overtempShutdown(overtemp_shutdown),
    .chargePumpFault(1'b0), .statusRead(rdCh), .globalOpenFlag(gFlag),
    .offTestEnable(offEn), .offTestDrive(offDrv), .ledTestCurrent(ledSrc),
    .ledDetectTrigger(trig), .outputLevelStat(lvlStat)
  );
  old_load_model LOAD (
    .sys_clk, .outputOn(outOn), .offTestDrive(offDrv), .openLoad(openLd),
    .loadCurrentLow(curLow), .offCurrentReached(curOk)
  );
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Sampling waits for the falling edge so register updates have landed.
  task automatic look(int n);
    tick(n);
    @(negedge sys_clk);
  endtask
  task automatic rd(int c);
    tick(1);
    rdCh <= old_chan_t'(1 << c);
    tick(1);
    rdCh <= '0;
  endtask
  task automatic wr(old_chan_t v);
    tick(1);
    wrEn  <= v;
    wrStb <= 1'b1;
    tick(1);
    wrStb  <= 1'b0;
    csRise <= 1'b1;
    tick(1);
    csRise <= 1'b0;
  endtask
  task automatic chkV(old_chan_t got, old_chan_t exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic chkS(old_stat_t got, old_stat_t exp, logic g, logic ge);
    checks_done++;
    if ({got, g} !== {exp, ge}) begin
      errors++;
      $display("Error at %0t: flags %h/%b, expected %h/%b", $time, got, g,
               exp, ge);
    end
  endtask
  task automatic conclude();
    $display("Checks %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // A hang is cut short well past the roughly 28000 cycles the tests need.
  initial begin
    #(40000 * 50);
    errors++;
    conclude();
  end
  // Main sequence: bulb deglitch, filter restart, off-state test, levels.
  initial begin
    tick(10);
    reset <= 1'b0;
    look(1);
    chkS(status, '0, gFlag, 1'b0);
    chkV(offDrv | offEn | lvlStat | ledSrc | old_chan_t'(trig), '0);
    tick(1);
    openLd <= 5'h01;
    outOn  <= 5'h01;
    look(1200);
    chkS(status, '0, gFlag, 1'b0);
    look(100);
    chkS(status, 15'h0420, gFlag, 1'b1);
    rd(0);
    look(2);
    chkS(status, 15'h0420, gFlag, 1'b1);
    tick(1);
    openLd <= '0;
    rd(0);
    look(3);
    chkS(status, '0, gFlag, 1'b0);
    tick(1);
    cfg.onOpenDeglitchSelect <= 5'h02;
    openLd <= 5'h03;
    outOn  <= 5'h03;
    tick(1000);
    outOn <= 5'h02;
    tick(2);
    outOn <= 5'h03;
    look(1000);
    chkS(status, '0, gFlag, 1'b0);
    look(300);
    chkS(status, 15'h0420, gFlag, 1'b1);
    tick(1);
    openLd <= 5'h04;
    outOn  <= '0;
    cfg    <= '0;
    rd(0);
    wr(5'h06);
    look(1);
    chkV(offDrv, 5'h06);
    wr(5'h00);
    look(100);
    chkV(offEn, 5'h04);
    chkV(offDrv, 5'h04);
    chkS(status, '0, gFlag, 1'b0);
    look(23800);
    chkV(offDrv, 5'h04);
    look(200);
    chkV(offDrv | offEn, '0);
    chkS(status, 15'h1004, gFlag, 1'b1);
    rd(2);
    look(3);
    chkS(status, '0, gFlag, 1'b0);
    tick(1);
    openLd <= 5'h05;
    wr(5'h01);
    look(4);
    chkV(offDrv, 5'h01);
    tick(1);
    overtemp_shutdown <= 1'b1;
    look(80);
    chkV(offDrv | offEn, '0);
    chkS(status, '0, gFlag, 1'b0);
    tick(1);
    overtemp_shutdown    <= 1'b0;
    openLd <= 5'h04;
    cfg.ledDetectEnable <= 5'h08;
    outOn  <= 5'h08;
    ledHi  <= 5'h08;
    tick(3);
    outOn <= '0;
    look(3);
    chkV(ledSrc, 5'h08);
    tick(1);
    outOn <= 5'h08;
    look(3);
    chkS(status, 15'h2100, gFlag, 1'b1);
    chkV(ledSrc, '0);
    rd(3);
    look(3);
    chkS(status, '0, gFlag, 1'b0);
    tick(1);
    ledHi <= '0;
    outOn <= '0;
    look(3);
    chkV(ledSrc, '0);
    chkS(status, '0, gFlag, 1'b0);
    tick(1);
    lvl <= 5'h15;
    look(2);
    chkV(lvlStat, 5'h15);
    tick(1);
    uv <= 1'b1;
    look(2);
    chkV(lvlStat, '0);
    conclude();
  end
endmodule
